//--- logic/dat_top.sv
// dat_top: channel activity status, one shared time-out tick prescaler with per-channel selects
// and the two time-out counters, behind an apb slave.
// assumes the transfer engine drives chan_busy synchronously to clk.
// limits: status shows the engine's busy lines one cycle late, and a
// select change moves the next tick at once rather than at a boundary
`timescale 1ns/10ps
module dat_top #(
  parameter int NUM_CH = 5  // channels reported in the status word
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  input  wire logic [NUM_CH-1:0] chan_busy,
  output logic [1:0]             timeout_tick,
  output logic [1:0]             timeout_event
);

  // elaboration-time guard: status word holds at most 32 channels,
  // and fewer than two leaves no channel for the second timer
  if (NUM_CH < 2 || NUM_CH > 32) begin : g_bad_ch
    $error("NUM_CH must be between 2 and 32");
  end

  // all block state lives in one packed struct: one always_comb builds
  // the next copy and one always_ff registers it, so every output is a
  // flop and there is no second clocked process to keep in step
  //
  // register map seen on paddr (byte addresses, one word each):
  //   status    - channel activity flags, read only
  //   prescale  - tick divider selects for channels 0 and 1
  //   enable    - time-out enables for channels 0 and 1
  //   counts    - 16-bit reload counts, channel 0 in the low half
  // anything else answers with pslverr and reads zero; writes to the
  // status word answer normally but change nothing
  //
  typedef struct packed {
    logic [NUM_CH-1:0]                   channel_active_flag;
    logic [dat_pkg::SEL_W-1:0]           ch0_tick_divider_select;
    logic [dat_pkg::SEL_W-1:0]           ch1_tick_divider_select;
    logic [dat_pkg::TO_CH-1:0]           timeout_function_enable;
    logic [dat_pkg::COUNT_W-1:0]         count0;    // reload value ch0
    logic [dat_pkg::COUNT_W-1:0]         count1;    // reload value ch1
    logic [dat_pkg::COUNT_W-1:0]         remain0;   // ticks left ch0
    logic [dat_pkg::COUNT_W-1:0]         remain1;   // ticks left ch1
    logic [dat_pkg::PRE_W-1:0]           pre_cnt;   // free-running
    logic [1:0]                          tick;
    logic [1:0]                          expire;
    logic                                ready;
    logic [31:0]                         rdata;
    logic                                slverr;
  } dat_state_t;

  // st is what the flops hold now, next_st what they take next edge
  dat_state_t st;       // registered state
  dat_state_t next_st;  // next value

  // the prescaler is one shared free-running counter, not one per
  // channel: a select change takes hold at once with no restart, at
  // the cost of a first tick that may land anywhere in the new period
  // tick when the low (8+sel) bits of the counter are about to wrap,
  // so each tick is exactly one cycle wide and one division apart
  function automatic logic tick_due(
    input logic [dat_pkg::PRE_W-1:0] cnt,
    input logic [dat_pkg::SEL_W-1:0] sel
  );
    logic [dat_pkg::PRE_W-1:0] mask;
    // low 8+sel bits set; the widest case, select 7, fills all 15
    mask = dat_pkg::PRE_W'((32'd1 << (dat_pkg::DIV_EXP_BASE + 32'(sel)))
                           - 32'd1);
    return (cnt & mask) == mask;
  endfunction

  // the timer only runs while its enable is set and the channel is
  // busy; once it reaches zero it parks there, so one stall gives one
  // event until the channel goes idle or the enable drops
  // a count of zero never fires, which leaves an unset timer harmless
  // one timer step: reload while disabled or idle, count down on ticks
  function automatic logic [dat_pkg::COUNT_W:0] timer_step(
    input logic                        en,
    input logic                        busy,
    input logic                        tk,
    input logic [dat_pkg::COUNT_W-1:0] rem,
    input logic [dat_pkg::COUNT_W-1:0] load
  );
    logic [dat_pkg::COUNT_W-1:0] nr;
    logic                        ex;
    nr = rem;
    ex = 1'b0;
    // idle or disabled: keep the reload value ready for the next stall
    if (!en || !busy) begin
      nr = load;
    end else if (tk && rem != '0) begin
      nr = rem - dat_pkg::COUNT_W'(1);
      ex = (rem == dat_pkg::COUNT_W'(1));
    end
    // expiry flag rides on top of the new remainder
    return {ex, nr};
  endfunction

  // an access is served once: the first access-phase cycle raises
  // ready, and ready itself blocks a second hit in the next cycle, so
  // a master that holds penable over the answer is not served twice
  logic setup_ok;  // access phase of an apb transfer
  assign setup_ok = psel && penable && !st.ready;

  // next-state logic for the whole block
  always_comb begin
    logic [dat_pkg::COUNT_W:0] r0;
    logic [dat_pkg::COUNT_W:0] r1;
    next_st = st;
    r0 = '0;
    r1 = '0;
    // activity flags follow the engine; idle reads zero
    next_st.channel_active_flag = chan_busy;
    // prescaler wraps at 2^15, the longest division; every shorter one
    // is a mask of its low bits, so all selects share one counter
    next_st.pre_cnt = st.pre_cnt + dat_pkg::PRE_W'(1);
    next_st.tick[0] = tick_due(st.pre_cnt,
                               st.ch0_tick_divider_select);
    next_st.tick[1] = tick_due(st.pre_cnt,
                               st.ch1_tick_divider_select);
    // time-out timers: busy comes from the registered flags, so a
    // stall is timed from the cycle the status word first shows it
    r0 = timer_step(st.timeout_function_enable[0],
                    st.channel_active_flag[0], st.tick[0],
                    st.remain0, st.count0);
    r1 = timer_step(st.timeout_function_enable[1],
                    st.channel_active_flag[1], st.tick[1],
                    st.remain1, st.count1);
    next_st.remain0 = r0[dat_pkg::COUNT_W-1:0];
    next_st.remain1 = r1[dat_pkg::COUNT_W-1:0];
    // expiry pulses last one cycle, like the ticks
    next_st.expire = {r1[dat_pkg::COUNT_W], r0[dat_pkg::COUNT_W]};
    // apb: one wait state, answer the cycle after penable rises
    // rdata and slverr default to zero so both read as zero outside
    // the answer cycle
    next_st.ready  = setup_ok;
    next_st.slverr = 1'b0;
    next_st.rdata  = dat_pkg::ZERO_WORD;
    if (setup_ok) begin
      if (paddr == dat_pkg::ACT_STATUS_OFS) begin
        // writes dropped, upper bits zero
        // the flags already carry the one-cycle delay of the busy flops
        if (!pwrite) begin
          next_st.rdata = 32'(st.channel_active_flag);
        end
      end else if (paddr == dat_pkg::PRESCALE_OFS) begin
        // only the two select fields are stored; the rest reads zero
        if (pwrite) begin
          next_st.ch0_tick_divider_select =
            pwdata[dat_pkg::CH0_SEL_LSB +: dat_pkg::SEL_W];
          next_st.ch1_tick_divider_select =
            pwdata[dat_pkg::CH1_SEL_LSB +: dat_pkg::SEL_W];
        end else begin
          next_st.rdata[dat_pkg::CH0_SEL_LSB +: dat_pkg::SEL_W] =
            st.ch0_tick_divider_select;
          next_st.rdata[dat_pkg::CH1_SEL_LSB +: dat_pkg::SEL_W] =
            st.ch1_tick_divider_select;
        end
      end else if (paddr == dat_pkg::TO_ENABLE_OFS) begin
        // two enable bits kept, reserved bits dropped
        if (pwrite) begin
          next_st.timeout_function_enable =
            pwdata[dat_pkg::TO_CH-1:0];
        end else begin
          next_st.rdata[dat_pkg::TO_CH-1:0] = st.timeout_function_enable;
        end
      end else if (paddr == dat_pkg::TO_COUNT_OFS) begin
        // low half reloads channel 0, high half channel 1
        if (pwrite) begin
          next_st.count0 = pwdata[dat_pkg::COUNT_W-1:0];
          next_st.count1 = pwdata[2*dat_pkg::COUNT_W-1:dat_pkg::COUNT_W];
        end else begin
          next_st.rdata = {st.count1, st.count0};
        end
      end else begin
        // unmapped address: error answer, reads zero
        next_st.slverr = 1'b1;
      end
    end
  end

  // state register; every field resets to a constant
  // reset clears everything: selects to divide-by-256, timers
  // disabled, status all idle, bus answer quiet
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from flip-flops
  // no output logic of its own: the port values are the flops, which
  // keeps the answer one clean cycle after the access phase
  assign pready        = st.ready;
  assign prdata        = st.rdata;
  assign pslverr       = st.slverr;
  assign timeout_tick  = st.tick;
  assign timeout_event = st.expire;

endmodule

//--- logic/dat_pkg.sv
// dat_pkg: register map, field layout and reset values for the dma
// activity / time-out prescaler slice.
// assumes a 32-bit apb register bus and one system bus clock.
package dat_pkg;
  // register byte offsets
  localparam logic [11:0] ACT_STATUS_OFS = 12'h042C;
  localparam logic [11:0] PRESCALE_OFS   = 12'h0430;
  localparam logic [11:0] TO_ENABLE_OFS  = 12'h0434;
  localparam logic [11:0] TO_COUNT_OFS   = 12'h0440;
  // prescaler select fields
  localparam int CH0_SEL_LSB = 0;
  localparam int CH1_SEL_LSB = 4;
  localparam int SEL_W       = 3;
  // smallest divide exponent (divide by 2^8)
  localparam int DIV_EXP_BASE = 8;
  localparam int DIV_EXP_MAX  = 15;
  // field widths
  localparam int COUNT_W = 16;
  localparam int TO_CH   = 2;
  // reset values
  localparam logic [31:0] PRESCALE_RST = 32'h0000_0000;
  localparam logic [31:0] ZERO_WORD    = 32'h0000_0000;
  // free-running prescale counter width
  localparam int PRE_W = DIV_EXP_MAX;
endpackage

//--- tb/dat_properties.sv
// dat_props: apb answer, status word and tick spacing checks
// assumes one clock, async active-high reset, ports of dat_top only
`timescale 1ns/10ps
module dat_props #(parameter int NUM_CH = 5) (
  input wire logic              clk, rst, psel, penable, pwrite,
  input wire logic              pready, pslverr,
  input wire logic [11:0]       paddr,
  input wire logic [31:0]       pwdata, prdata,
  input wire logic [NUM_CH-1:0] chan_busy,
  input wire logic [1:0]        timeout_tick, timeout_event
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // answered reads of the status and prescale words
  wire rd_st = pready && !pwrite && paddr == 12'h042C;
  wire rd_ps = pready && !pwrite && paddr == 12'h0430;
  property p_wait; psel && penable && !pready |=> pready; endproperty
  a_wait: assert property (p_wait) else $error("pready late");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("pready held");
  property p_err; pslverr |-> pready && prdata == '0; endproperty
  a_err: assert property (p_err) else $error("bad error answer");
  property p_hi; rd_st |-> prdata[31:5] == '0; endproperty
  a_hi: assert property (p_hi) else $error("status upper set");
  // busy must be steady long enough to pass the status delay
  property p_idle; chan_busy == '0 [*3] ##1 rd_st |-> prdata[4:0] == '0;
  endproperty
  a_idle: assert property (p_idle) else $error("idle flag set");
  property p_busy; &chan_busy [*3] ##1 rd_st |-> prdata[4:0] == 5'h1F;
  endproperty
  a_busy: assert property (p_busy) else $error("busy flag clear");
  property p_ps; rd_ps |-> prdata[31:7] == '0 && !prdata[3]; endproperty
  a_ps: assert property (p_ps) else $error("reserved psc bit");
  // shortest divide is 256, so a tick is never followed closely
  property p_t0; timeout_tick[0] |=> !timeout_tick[0] [*8]; endproperty
  a_t0: assert property (p_t0) else $error("tick0 too close");
  property p_t1; timeout_tick[1] |=> !timeout_tick[1] [*8]; endproperty
  a_t1: assert property (p_t1) else $error("tick1 too close");
  c_st: cover property (rd_st);
  c_err: cover property (pslverr);
  c_t1: cover property (timeout_tick[1]);
  c_evt: cover property (timeout_event[0]);
endmodule
bind dat_top dat_props #(.NUM_CH(NUM_CH)) u_props (.clk(clk), .rst(rst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready),
  .pslverr(pslverr), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .chan_busy(chan_busy), .timeout_tick(timeout_tick),
  .timeout_event(timeout_event));

//--- tb/testbench.sv
// testbench: apb master, read data queue, tick period measurement
// assumes dat_pkg, dat_top and the checker are compiled first
`timescale 1ns/10ps
module testbench;
  logic        clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h0000;
  logic [31:0] pwdata = 32'h0000_0000, prdata;
  logic        pready, pslverr;
  logic [4:0]  chan_busy = 5'h00;
  logic [1:0]  timeout_tick, timeout_event;
  logic [15:0] lf = 16'h846C;  // lfsr seed 33900
  logic [31:0] exp_q[$];       // expected read data, oldest first
  logic        exp_e[$];       // expected pslverr per transfer
  int          err_total = 0, checks = 0, cyc = 0, n, k, ev0 = 0, ev1 = 0;
  always #25 clk = ~clk;
  dat_top dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .chan_busy(chan_busy),
    .timeout_tick(timeout_tick), .timeout_event(timeout_event));
  function automatic logic [15:0] step(logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic cmp(string nm, logic [31:0] e, logic [31:0] g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wrap_up();
    if (err_total == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // request held until pready is seen high at a rising edge
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d,
                     logic [31:0] e);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w) exp_q.push_back(e);
    exp_e.push_back(!(a inside {12'h042C, 12'h0430, 12'h0434, 12'h0440}));
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // cycles from one tick of a channel to its next
  task automatic gap(int ch, int e);
    @(posedge clk iff timeout_tick[ch] === 1'b1);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (timeout_tick[ch] !== 1'b1);
    cmp("tick gap", e, n);
  endtask
  // ticks counted from a busy start until the channel's expiry pulse
  task automatic tmo(int ch, int e);
    k = 0;
    @(posedge clk);
    do begin
      @(posedge clk);
      if (timeout_event[ch] !== 1'b1 && timeout_tick[ch] === 1'b1) k++;
    end while (timeout_event[ch] !== 1'b1 && k <= e);
    cmp("expiry ticks", e, k);
  endtask
  // monitor: each read answer takes the oldest note; also the hang limit
  always @(posedge clk) begin
    cyc++;
    if (pready === 1'b1 && pwrite === 1'b0)
      cmp("prdata", exp_q.pop_front(), prdata);
    if (pready === 1'b1)
      cmp("pslverr", exp_e.pop_front(), pslverr);
    if (timeout_event[0] === 1'b1) ev0++;
    if (timeout_event[1] === 1'b1) ev1++;
    if (cyc == 20000) begin
      err_total++;
      wrap_up();
    end
  end
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    apb(0, 12'h042C, 0, 32'h0000_0000);
    apb(0, 12'h0430, 0, 32'h0000_0000);
    apb(1, 12'h042C, 32'hFFFF_FFFF, 0);
    apb(0, 12'h042C, 0, 32'h0000_0000);
    apb(1, 12'h0430, 32'hFFFF_FFFF, 0);
    apb(0, 12'h0430, 0, 32'h0000_0077);
    apb(0, 12'h0000, 0, 32'h0000_0000);
    for (int i = 0; i < 5; i++) begin
      lf = step(lf);
      if (i == 0) lf[4:0] = 5'h1F;
      chan_busy <= lf[4:0];
      apb(0, 12'h042C, 0, {27'h0, lf[4:0]});
    end
    for (int s = 0; s < 3; s++) begin
      apb(1, 12'h0430, ((s + 1) << 4) | s, 0);
      gap(0, 1 << (8 + s));
      gap(1, 1 << (9 + s));
    end
    // expiry: shortest ticks, counts 2 and 1, one channel enabled a time
    apb(1, 12'h0430, 0, 0);
    apb(1, 12'h0440, 32'h0001_0002, 0);
    apb(0, 12'h0440, 0, 32'h0001_0002);
    chan_busy <= 5'h00;
    apb(1, 12'h0434, 32'hFFFF_FFFD, 0);
    apb(0, 12'h0434, 0, 32'h0000_0001);
    chan_busy <= 5'h03;
    tmo(0, 2);
    cmp("ch1 expiry", 0, ev1);
    chan_busy <= 5'h00;
    apb(1, 12'h0434, 32'h0000_0002, 0);
    chan_busy <= 5'h03;
    tmo(1, 1);
    cmp("ch0 expiry", 1, ev0);
    wrap_up();
  end
endmodule
